// ==== include/slq_pkg.sv ====
// Purpose: Shared constants, types and carriers of the sleep, pin status and liquid block
// Assumes: 10 MHz ref_clk, AXI4-Lite register access with 32-bit data
// Notes:   Printed offsets are word indexes; byte address is four times the index
package slq_pkg;

	// Clock and time bases
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned TICK_MS        = 1;
	localparam int unsigned TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned SLEEP_SHORT_MS = 100;
	localparam int unsigned SLEEP_LONG_MS  = 1200;
	localparam int unsigned SAMPLE_UNIT_MS = 10;
	localparam int unsigned REST_UNIT_MS   = 1000;

	// Register indexes and byte addresses
	localparam logic [7:0]  IDX_SLEEP  = 8'h70;
	localparam logic [7:0]  IDX_PINS   = 8'h72;
	localparam logic [7:0]  IDX_LIQ    = 8'h98;
	localparam logic [11:0] A_SLEEP    = {2'h0, IDX_SLEEP, 2'h0};
	localparam logic [11:0] A_PINS     = {2'h0, IDX_PINS, 2'h0};
	localparam logic [11:0] A_LIQ      = {2'h0, IDX_LIQ, 2'h0};
	localparam logic [11:0] A_IRQ_STAT = 12'h300;
	localparam logic [11:0] A_IRQ_MASK = 12'h304;
	localparam logic [11:0] A_STATE    = 12'h308;

	// Reset values
	localparam logic [7:0]  SLEEP_RST = 8'h01;
	localparam logic [82:0] LIQ_RST   = 83'h0;
	localparam logic [2:0]  IRQ_RST   = 3'h0;

	// Sleep control fields and codes
	localparam int unsigned SC_ALLOW   = 0;
	localparam int unsigned SC_TIME    = 1;
	localparam logic [1:0]  SLP_SHORT  = 2'h1;
	localparam logic [1:0]  SLP_LONG   = 2'h2;

	// Pin status fields
	localparam int unsigned GS_DIR     = 32;
	localparam int unsigned GS_HI_PIN  = 12;

	// Liquid configuration fields
	localparam int unsigned LQ_EN      = 82;
	localparam int unsigned LQ_CORR    = 81;
	localparam int unsigned LQ_STATE   = 80;
	localparam int unsigned LQ_SMP_WET = 76;
	localparam int unsigned LQ_SMP_DRY = 72;
	localparam int unsigned LQ_HI_WET  = 64;
	localparam int unsigned LQ_LO_WET  = 56;
	localparam int unsigned LQ_HI_DRY  = 48;
	localparam int unsigned LQ_LO_DRY  = 40;
	localparam int unsigned LQ_NSMP    = 32;
	localparam int unsigned LQ_SLP_WET = 16;
	localparam int unsigned LQ_SLP_DRY = 0;

	// Interrupt status bits
	localparam int unsigned EV_WET   = 0;
	localparam int unsigned EV_DRY   = 1;
	localparam int unsigned EV_SLEEP = 2;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Liquid detection sequencer states
	typedef enum logic [2:0] {LD_OFF, LD_WAIT, LD_REQ, LD_CHECK, LD_REST} slq_ld_t;

	// Master to slave signals
	typedef struct packed {
		logic        awvalid;
		logic [11:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [11:0] araddr;
		logic        rready;
	} slq_axi_req_t;

	// Slave to master signals
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} slq_axi_rsp_t;

endpackage : slq_pkg

// ==== rtl/slq_tick.sv ====
// Purpose: Millisecond enable pulse from ref_clk
// Assumes: CYCLES is at least two
// Notes:   One-cycle pulse every CYCLES clocks
`timescale 1ns/1ns
module slq_tick #(
	parameter int unsigned CYCLES = slq_pkg::TICK_CYC
) (
	input  wire logic ref_clk,
	input  wire logic resetn,
	output logic      tick
);

	// Whole state: divider count and pulse
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} slq_tick_st_t;

	slq_tick_st_t s;      // Registered state
	slq_tick_st_t next_s; // Next state

	////////////////////////////////////////////////////////////////////////////
	// Divider
	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		// Wrap and pulse on the last count
		if (s.cnt == 16'(CYCLES - 1))
		begin
			next_s.cnt  = 16'h0000;
			next_s.tick = 1'b1;
		end
		else
			next_s.cnt = s.cnt + 16'h0001;
	end

	// State register
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick = s.tick;

endmodule : slq_tick

// ==== rtl/slq_avg.sv ====
// Purpose: Averages a power-of-two number of 8-bit samples
// Assumes: Count code zero is taken as one sample
// Notes:   A count that is not a power of two shifts the sum right by its floor log2
`timescale 1ns/1ns
module slq_avg (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       clear,
	input  wire logic       smp_valid,
	input  wire logic [7:0] smp,
	input  wire logic [7:0] count,
	output logic            done,
	output logic [7:0]      avg
);

	// Whole state: sum, samples taken, result
	typedef struct packed {
		logic [15:0] acc;
		logic [7:0]  cnt;
		logic        done;
		logic [7:0]  avg;
	} slq_avg_st_t;

	slq_avg_st_t s;      // Registered state
	slq_avg_st_t next_s; // Next state

	// Floor log2 of the sample count
	function automatic logic [3:0] log2f(input logic [7:0] n);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 1; i < 8; i++)
			if (n[i])
				r = 4'(i);
		return r;
	endfunction : log2f

	////////////////////////////////////////////////////////////////////////////
	// Accumulate and divide by shifting
	always_comb
	begin
		logic [15:0] sum;
		logic [7:0]  need;
		sum    = s.acc + {8'h00, smp};
		need   = (count == 8'h00) ? 8'h01 : count;
		next_s = s;
		next_s.done = 1'b0;
		if (clear)
		begin
			next_s.acc = 16'h0000;
			next_s.cnt = 8'h00;
		end
		else if (smp_valid)
		begin
			// Last sample closes the batch and restarts the sum
			if (s.cnt + 8'h01 >= need) // R10
			begin
				next_s.avg  = 8'(sum >> log2f(need)); // R10
				next_s.done = 1'b1;
				next_s.acc  = 16'h0000;
				next_s.cnt  = 8'h00;
			end
			else
			begin
				next_s.acc = sum;
				next_s.cnt = s.cnt + 8'h01;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign done = s.done;
	assign avg  = s.avg;

endmodule : slq_avg

// ==== rtl/slq_regs.sv ====
// Purpose: Sleep control, pin status snapshot and liquid detection registers
// Assumes: AXI4-Lite slave, one write and one read outstanding at most
// Notes:   Printed offsets are word indexes; wide registers span consecutive words
//
// How it works
// R01: Sleep code 1 is 100 ms, 2 is 1200 ms
// R02: Allow bit set: sleep after idle delay
// R03: Bits 39..32 show pins configured as outputs
// R04: Bits 7..0 and 12 show high pin levels
// R05: Bit 82 enables liquid detection sequencing
// R06: Mitigation disconnects, disables port, pulls CC down
// R07: Sample intervals in 10 ms, wet and dry
// R08: Wet window from high and low thresholds
// R09: Dry thresholds govern leaving liquid state
// R10: Average a power-of-two sample count
// R11: Rest periods in seconds, wet and dry
// R12: Pin status reserved bits read zero, unwritable
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module slq_regs #(
	parameter int unsigned TICK_CYCLES = slq_pkg::TICK_CYC
) (
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	input  wire slq_pkg::slq_axi_req_t axi_req,
	output slq_pkg::slq_axi_rsp_t      axi_rsp,
	input  wire logic                  device_idle,
	input  wire logic [7:0]            gpio_dir,
	input  wire logic [12:0]           gpio_level,
	input  wire logic                  adc_valid,
	input  wire logic [7:0]            adc_data,
	output logic                       adc_req,
	output logic                       sleep_mode,
	output logic                       liquid_present,
	output logic                       port_disconnect,
	output logic                       port_disable,
	output logic                       cc_pulldown,
	output logic                       irq
);

	// Whole state of the block
	typedef struct packed {
		logic            aw_have;   // Write address held
		logic [11:0]     aw_addr;
		logic            w_have;    // Write data held
		logic [31:0]     w_data;
		logic [3:0]      w_strb;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
		logic [7:0]      sleep_ctl; // Sleep control register
		logic [82:0]     liq_cfg;   // Liquid configuration register
		logic [63:0]     pins;      // Pin status snapshot
		logic [2:0]      irq_stat;
		logic [2:0]      irq_mask;
		logic [10:0]     idle_ms;   // Saturating idle time
		logic            sleeping;
		slq_pkg::slq_ld_t ld;
		logic [9:0]      ms_cnt;    // Milliseconds inside one unit
		logic [15:0]     unit_cnt;  // Units elapsed
		logic            adc_req;
		logic            mitigate;
	} slq_st_t;

	slq_st_t    s;         // Registered state
	slq_st_t    next_s;    // Next state
	logic       tick;      // Millisecond enable
	logic       avg_done;  // Batch average ready
	logic [7:0] avg;       // Batch average
	logic       avg_clear; // Restart averaging
	logic       aw_rdy;
	logic       w_rdy;
	logic       ar_rdy;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Merge write data into a word under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = d[8*b +: 8];
		return r;
	endfunction : merge

	// Sleep delay in milliseconds for a code, zero when reserved
	function automatic logic [10:0] sleep_limit(input logic [1:0] code);
		logic [10:0] r;
		r = 11'h000;
		if (code == slq_pkg::SLP_SHORT)
			r = 11'(slq_pkg::SLEEP_SHORT_MS); // R01
		else if (code == slq_pkg::SLP_LONG)
			r = 11'(slq_pkg::SLEEP_LONG_MS); // R01
		return r;
	endfunction : sleep_limit

	// Register read decode; bit 32 flags a mapped address
	function automatic logic [32:0] rd_word(input logic [11:0] a, input slq_st_t t);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		unique case (a)
			slq_pkg::A_SLEEP:          r[7:0]  = t.sleep_ctl;
			slq_pkg::A_PINS:           r[31:0] = t.pins[31:0];
			slq_pkg::A_PINS + 12'h004: r[31:0] = t.pins[63:32];
			slq_pkg::A_LIQ:            r[31:0] = t.liq_cfg[31:0];
			slq_pkg::A_LIQ + 12'h004:  r[31:0] = t.liq_cfg[63:32];
			slq_pkg::A_LIQ + 12'h008:  r[18:0] = t.liq_cfg[82:64];
			slq_pkg::A_IRQ_STAT:       r[2:0]  = t.irq_stat;
			slq_pkg::A_IRQ_MASK:       r[2:0]  = t.irq_mask;
			slq_pkg::A_STATE:          r[2:0]  = {t.mitigate, t.sleeping, t.liq_cfg[80]};
			default:                   r[32]   = 1'b0;
		endcase
		return r;
	endfunction : rd_word

	////////////////////////////////////////////////////////////////////////////
	// Time base and averaging

	slq_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.tick    (tick)
	);

	// Disabling detection drops any partial batch
	assign avg_clear = !s.liq_cfg[slq_pkg::LQ_EN];

	slq_avg u_avg (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.clear     (avg_clear),
		.smp_valid (adc_valid && s.ld == slq_pkg::LD_REQ),
		.smp       (adc_data),
		.count     (s.liq_cfg[slq_pkg::LQ_NSMP +: 8]),
		.done      (avg_done),
		.avg       (avg)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb
	begin
		logic [32:0] rd;
		logic [31:0] wd;
		logic [2:0]  ev;
		logic [10:0] lim;
		logic [9:0]  unit_ms;
		logic [15:0] target;
		logic        wet;
		logic        expire;
		logic [7:0]  hi;
		logic [7:0]  lo;
		rd      = rd_word(axi_req.araddr, s);
		wd      = 32'h0000_0000;
		ev      = 3'h0;
		lim     = sleep_limit(s.sleep_ctl[slq_pkg::SC_TIME +: 2]);
		wet     = s.liq_cfg[slq_pkg::LQ_STATE];
		unit_ms = 10'(slq_pkg::SAMPLE_UNIT_MS);
		target  = 16'h0000;
		expire  = 1'b0;
		hi      = 8'h00;
		lo      = 8'h00;
		next_s  = s;
		next_s.adc_req = 1'b0;

		// Channel acceptance; write side stalls while a response waits
		aw_rdy = !s.aw_have && !s.bvalid;
		w_rdy  = !s.w_have && !s.bvalid;
		ar_rdy = !s.rvalid;
		if (axi_req.awvalid && aw_rdy)
		begin
			next_s.aw_have = 1'b1;
			next_s.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && w_rdy)
		begin
			next_s.w_have = 1'b1;
			next_s.w_data = axi_req.wdata;
			next_s.w_strb = axi_req.wstrb;
		end
		if (s.bvalid && axi_req.bready)
			next_s.bvalid = 1'b0;
		if (s.rvalid && axi_req.rready)
			next_s.rvalid = 1'b0;

		// Read: data captured as the address is taken
		if (axi_req.arvalid && ar_rdy)
		begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rd[31:0];
			next_s.rresp  = rd[32] ? slq_pkg::RESP_OKAY : slq_pkg::RESP_SLVERR;
		end

		// Write: performed once address and data are both held
		if (s.aw_have && s.w_have)
		begin
			next_s.aw_have = 1'b0;
			next_s.w_have  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = slq_pkg::RESP_OKAY;
			unique case (s.aw_addr)
				slq_pkg::A_SLEEP:
				begin
					wd = merge({24'h000000, s.sleep_ctl}, s.w_data, s.w_strb);
					next_s.sleep_ctl = wd[7:0];
				end
				slq_pkg::A_PINS, slq_pkg::A_PINS + 12'h004:
					; // Read-only snapshot, write ignored // R12
				slq_pkg::A_LIQ:
					next_s.liq_cfg[31:0] = merge(s.liq_cfg[31:0], s.w_data, s.w_strb);
				slq_pkg::A_LIQ + 12'h004:
					next_s.liq_cfg[63:32] = merge(s.liq_cfg[63:32], s.w_data, s.w_strb);
				slq_pkg::A_LIQ + 12'h008:
				begin
					wd = merge({13'h0000, s.liq_cfg[82:64]}, s.w_data, s.w_strb);
					next_s.liq_cfg[82:64] = wd[18:0];
				end
				slq_pkg::A_IRQ_STAT:
					if (s.w_strb[0])
						next_s.irq_stat = s.irq_stat & ~s.w_data[2:0];
				slq_pkg::A_IRQ_MASK:
					if (s.w_strb[0])
						next_s.irq_mask = s.w_data[2:0];
				slq_pkg::A_STATE:
					; // Read-only state word
				default:
					next_s.bresp = slq_pkg::RESP_SLVERR;
			endcase
		end

		// Pin snapshot; reserved positions stay zero
		next_s.pins = '0; // R12
		next_s.pins[slq_pkg::GS_DIR +: 8] = gpio_dir; // R03
		next_s.pins[7:0] = gpio_level[7:0]; // R04
		next_s.pins[slq_pkg::GS_HI_PIN] = gpio_level[12]; // R04

		// Idle timer; reserved delay codes never allow sleep
		if (!device_idle || !s.sleep_ctl[slq_pkg::SC_ALLOW] || lim == 11'h000)
		begin
			next_s.idle_ms  = 11'h000;
			next_s.sleeping = 1'b0;
		end
		else
		begin
			if (tick && s.idle_ms < lim)
				next_s.idle_ms = s.idle_ms + 11'h001; // R01
			next_s.sleeping = s.idle_ms >= lim; // R02
			if (!s.sleeping && s.idle_ms >= lim)
				ev[slq_pkg::EV_SLEEP] = 1'b1;
		end

		// Unit timer shared by sample waits and rest periods
		if (s.ld == slq_pkg::LD_WAIT)
			target = {12'h000, s.liq_cfg[(wet ? slq_pkg::LQ_SMP_WET
				: slq_pkg::LQ_SMP_DRY) +: 4]}; // R07
		else
		begin
			unit_ms = 10'(slq_pkg::REST_UNIT_MS); // R11
			target  = s.liq_cfg[(wet ? slq_pkg::LQ_SLP_WET : slq_pkg::LQ_SLP_DRY) +: 16]; // R11
		end
		expire = s.unit_cnt >= target;
		if (tick && !expire)
		begin
			if (s.ms_cnt == unit_ms - 10'h001)
			begin
				next_s.ms_cnt   = 10'h000;
				next_s.unit_cnt = s.unit_cnt + 16'h0001;
			end
			else
				next_s.ms_cnt = s.ms_cnt + 10'h001;
		end

		// Liquid detection sequencer
		unique case (s.ld)
			slq_pkg::LD_OFF:
				if (s.liq_cfg[slq_pkg::LQ_EN]) // R05
				begin
					next_s.ld       = slq_pkg::LD_WAIT;
					next_s.ms_cnt   = 10'h000;
					next_s.unit_cnt = 16'h0000;
				end
			slq_pkg::LD_WAIT:
				if (expire)
				begin
					next_s.ld      = slq_pkg::LD_REQ;
					next_s.adc_req = 1'b1;
				end
			slq_pkg::LD_REQ:
				if (adc_valid)
					next_s.ld = slq_pkg::LD_CHECK;
			slq_pkg::LD_CHECK:
			begin
				next_s.ms_cnt   = 10'h000;
				next_s.unit_cnt = 16'h0000;
				next_s.ld       = slq_pkg::LD_WAIT;
				if (avg_done)
				begin
					next_s.ld = slq_pkg::LD_REST;
					if (!wet)
					begin
						// Enter liquid when the average falls inside the wet window
						hi = s.liq_cfg[slq_pkg::LQ_HI_WET +: 8]; // R08
						lo = s.liq_cfg[slq_pkg::LQ_LO_WET +: 8]; // R08
						if (avg >= lo && avg <= hi)
						begin
							next_s.liq_cfg[slq_pkg::LQ_STATE] = 1'b1;
							ev[slq_pkg::EV_WET] = 1'b1;
						end
					end
					else
					begin
						// Leave only when outside the wider dry window
						hi = s.liq_cfg[slq_pkg::LQ_HI_DRY +: 8]; // R09
						lo = s.liq_cfg[slq_pkg::LQ_LO_DRY +: 8]; // R09
						if (avg < lo || avg > hi)
						begin
							next_s.liq_cfg[slq_pkg::LQ_STATE] = 1'b0; // R09
							ev[slq_pkg::EV_DRY] = 1'b1;
						end
					end
				end
			end
			slq_pkg::LD_REST:
				if (expire)
				begin
					next_s.ld       = slq_pkg::LD_WAIT;
					next_s.ms_cnt   = 10'h000;
					next_s.unit_cnt = 16'h0000;
				end
			default:
				next_s.ld = slq_pkg::LD_OFF;
		endcase
		// Disable wins over any step in progress
		if (!s.liq_cfg[slq_pkg::LQ_EN])
			next_s.ld = slq_pkg::LD_OFF; // R05

		// Mitigation only while liquid is seen and both enables are set
		next_s.mitigate = s.liq_cfg[slq_pkg::LQ_EN] && s.liq_cfg[slq_pkg::LQ_CORR]
			&& s.liq_cfg[slq_pkg::LQ_STATE]; // R06

		// New events set status after the clear, so set wins
		next_s.irq_stat = next_s.irq_stat | ev;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s           <= '0;
			s.sleep_ctl <= slq_pkg::SLEEP_RST; // R02
			s.liq_cfg   <= slq_pkg::LIQ_RST;
			s.irq_stat  <= slq_pkg::IRQ_RST;
			s.irq_mask  <= slq_pkg::IRQ_RST;
			s.ld        <= slq_pkg::LD_OFF;
		end
		else
			s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb
	begin
		axi_rsp         = '0;
		axi_rsp.awready = aw_rdy;
		axi_rsp.wready  = w_rdy;
		axi_rsp.bvalid  = s.bvalid;
		axi_rsp.bresp   = s.bresp;
		axi_rsp.arready = ar_rdy;
		axi_rsp.rvalid  = s.rvalid;
		axi_rsp.rdata   = s.rdata;
		axi_rsp.rresp   = s.rresp;
	end

	assign adc_req         = s.adc_req;
	assign sleep_mode      = s.sleeping;
	assign liquid_present  = s.liq_cfg[slq_pkg::LQ_STATE];
	assign port_disconnect = s.mitigate; // R06
	assign port_disable    = s.mitigate; // R06
	assign cc_pulldown     = s.mitigate; // R06
	assign irq             = |(s.irq_stat & s.irq_mask);

endmodule : slq_regs

// ==== tb/slq_regs_chk.sv ====
// Purpose: Port-level checks for the sleep, pin status and liquid block
// Assumes: TICK_CYCLES equals the value the instance was built with
// Notes:   Bound to slq_regs from tb_top
`timescale 1ns/1ns
module slq_regs_chk #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic                  ref_clk,
	input wire logic                  resetn,
	input wire slq_pkg::slq_axi_req_t axi_req,
	input wire slq_pkg::slq_axi_rsp_t axi_rsp,
	input wire logic                  device_idle,
	input wire logic [7:0]            gpio_dir,
	input wire logic [12:0]           gpio_level,
	input wire logic                  adc_valid,
	input wire logic [7:0]            adc_data,
	input wire logic                  adc_req,
	input wire logic                  sleep_mode,
	input wire logic                  liquid_present,
	input wire logic                  port_disconnect,
	input wire logic                  port_disable,
	input wire logic                  cc_pulldown,
	input wire logic                  irq
);
	logic [15:0] idle_cnt; // Consecutive idle cycles seen

	////////////////////////////////////////////////////////////////////////////////
	// Idle run length; saturates so a long idle spell never wraps to a false early
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			idle_cnt <= 16'h0000;
		else if (!device_idle)
			idle_cnt <= 16'h0000;
		else if (idle_cnt != 16'hFFFF)
			idle_cnt <= idle_cnt + 16'h0001;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////////////////////
	// Shortest delay is 100 ms less one tick of phase slack
	sleep_wait_a: assert property ($rose(sleep_mode) |-> idle_cnt >= 16'(99 * TICK_CYCLES))
		else $error("sleep entered before the idle delay");
	sleep_idle_a: assert property (sleep_mode |-> $past(device_idle))
		else $error("sleep held without idle");
	mit_same_a: assert property (port_disconnect == port_disable && port_disable == cc_pulldown)
		else $error("mitigation outputs disagree");
	mit_cause_a: assert property ($rose(port_disconnect) |-> $past(liquid_present))
		else $error("mitigation without liquid");
	adc_pulse_a: assert property (adc_req |=> !adc_req)
		else $error("sample request longer than one cycle");
	rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=>
		axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data dropped");
	rd_stand_a: assert property ($fell(axi_rsp.rvalid) |-> $past(axi_req.rready))
		else $error("read answer withdrawn before taken");
	wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
		axi_rsp.wready |-> ##2 axi_rsp.bvalid)
		else $error("write answer late");
	ar_refuse_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("read taken while answer pending");
endmodule : slq_regs_chk

// ==== tb/tb_top.sv ====
// Purpose: Register, sleep, interrupt and liquid tests for slq_regs
// Assumes: 1 ms shortened to TICK cycles
// Notes:   ADC is answered one cycle after each request
`timescale 1ns/1ns
module tb_top;
	localparam int unsigned TICK = 4; // Cycles per ms in simulation
	logic                  ref_clk, resetn, device_idle, adc_req, sleep_mode;
	logic                  liquid_present, port_disconnect, port_disable, cc_pulldown, irq;
	logic                  adc_valid = 1'b0, req_seen = 1'b0, alt = 1'b0; // One driver each
	slq_pkg::slq_axi_req_t axi_req;
	slq_pkg::slq_axi_rsp_t axi_rsp;
	logic [7:0]            gpio_dir, smp_a, smp_b;
	logic [7:0]            adc_data = 8'h00; // Set here so only the stand-in drives it
	logic [12:0]           gpio_level;
	logic [31:0]           rdat;
	logic [1:0]            rsp;
	int                    n_fail, num_checks, n;
	logic [7:0]            sc [5] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h02}; // Sleep codes
	int                    sms [5] = '{0, 100, 1200, 0, 0};                // Expected ms

	slq_regs #(.TICK_CYCLES(TICK)) slq_regs_inst (.ref_clk(ref_clk), .resetn(resetn),
		.axi_req(axi_req), .axi_rsp(axi_rsp), .device_idle(device_idle), .gpio_dir(gpio_dir),
		.gpio_level(gpio_level), .adc_valid(adc_valid), .adc_data(adc_data), .adc_req(adc_req),
		.sleep_mode(sleep_mode), .liquid_present(liquid_present), .irq(irq),
		.port_disconnect(port_disconnect), .port_disable(port_disable), .cc_pulldown(cc_pulldown));

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// ADC stand-in: alternating samples prove the averaging; data is junk off the strobe
	always @(negedge ref_clk) req_seen = adc_req;
	always @(posedge ref_clk)
	begin
		adc_valid <= req_seen;
		adc_data  <= req_seen ? (alt ? smp_b : smp_a) : ~adc_data;
		alt       <= alt ^ req_seen;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		@(posedge ref_clk);
		axi_req.awaddr  <= a;
		axi_req.wdata   <= d;
		axi_req.wstrb   <= 4'hF;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid  <= 1'b1;
		axi_req.bready  <= 1'b1;
		do
		begin
			@(negedge ref_clk);
			aw_t = axi_req.awvalid && axi_rsp.awready;
			w_t  = axi_req.wvalid && axi_rsp.wready;
			b_t  = axi_rsp.bvalid;
			rsp  = axi_rsp.bresp;
			@(posedge ref_clk);
			if (aw_t)
				axi_req.awvalid <= 1'b0;
			if (w_t)
				axi_req.wvalid <= 1'b0;
		end while (b_t !== 1'b1);
		axi_req.bready <= 1'b0;
	endtask : wr

	// Read: address held until taken, rready held until the answer
	task automatic rd(input logic [11:0] a);
		logic ar_t, r_t;
		@(posedge ref_clk);
		axi_req.araddr  <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready  <= 1'b1;
		do
		begin
			@(negedge ref_clk);
			ar_t = axi_req.arvalid && axi_rsp.arready;
			r_t  = axi_rsp.rvalid;
			rdat = axi_rsp.rdata;
			rsp  = axi_rsp.rresp;
			@(posedge ref_clk);
			if (ar_t)
				axi_req.arvalid <= 1'b0;
		end while (r_t !== 1'b1);
		axi_req.rready <= 1'b0;
	endtask : rd

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		rd(a);
		chk(rdat, exp);
	endtask : rd_chk

	// Bounded wait on the liquid decision
	task automatic wait_liq(input logic v);
		n = 0;
		while (liquid_present !== v && n < 3000)
		begin
			@(negedge ref_clk);
			n++;
		end
	endtask : wait_liq

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: whole run needs about 25000 cycles
	initial
	begin
		repeat (80000) @(posedge ref_clk);
		n_fail++;
		close_out();
	end

	initial
	begin
		resetn      = 1'b0;
		axi_req     = '0;
		device_idle = 1'b0;
		smp_a       = 8'h10;
		smp_b       = 8'h50;
		gpio_dir    = 8'hA5;
		gpio_level  = 13'h1F3C;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		// Reset values, pin snapshot, read-only and unmapped places
		rd_chk(12'h1C0, 32'h01);
		rd_chk(12'h260, 32'h0);
		rd_chk(12'h264, 32'h0);
		rd_chk(12'h268, 32'h0);
		rd_chk(12'h1C8, 32'h103C);
		rd_chk(12'h1CC, 32'hA5);
		wr(12'h1C8, 32'hFFFFFFFF);
		chk(rsp, slq_pkg::RESP_OKAY);
		wr(12'h1CC, 32'hFFFFFFFF);
		rd_chk(12'h1C8, 32'h103C);
		rd_chk(12'h1CC, 32'hA5);
		rd_chk(12'h400, 32'h0);
		chk(rsp, slq_pkg::RESP_SLVERR);
		wr(12'h1C0, 32'hF9);
		rd_chk(12'h1C0, 32'hF9);
		$display("test regs done");
		// Every sleep code, and one with sleep not allowed
		for (int i = 0; i < 5; i++)
		begin
			wr(12'h1C0, {24'h0, sc[i]});
			@(posedge ref_clk);
			device_idle <= 1'b1;
			n = 0;
			while (sleep_mode !== 1'b1 && n < 5200)
			begin
				@(negedge ref_clk);
				n++;
			end
			if (sms[i] == 0)
				chk(n, 5200);
			else
				chk(n + TICK >= sms[i] * TICK && n <= sms[i] * TICK + TICK + 2, 1);
			@(posedge ref_clk);
			device_idle <= 1'b0;
		end
		$display("test sleep done");
		// Sleep event: masked, unmasked, cleared
		rd_chk(12'h300, 32'h4);
		chk(irq, 1'b0);
		wr(12'h304, 32'h4);
		@(negedge ref_clk);
		chk(irq, 1'b1);
		wr(12'h300, 32'h4);
		@(negedge ref_clk);
		chk(irq, 1'b0);
		wr(12'h304, 32'h3);
		$display("test irq done");
		// Liquid: two samples 0x10 and 0x50 average into the wet window
		wr(12'h260, 32'h1);
		wr(12'h264, 32'h20501002);
		wr(12'h268, 32'h00061140);
		n = 0;
		while (adc_req !== 1'b1 && n < 200)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk(n >= 39 && n <= 44, 1);
		wait_liq(1'b1);
		chk(liquid_present, 1'b1);
		chk(irq, 1'b1);
		@(negedge ref_clk);
		chk({port_disconnect, port_disable, cc_pulldown}, 3'h7);
		rd_chk(12'h308, 32'h5);
		smp_a <= 8'h05;
		smp_b <= 8'h05;
		wait_liq(1'b0);
		chk(liquid_present, 1'b0);
		rd_chk(12'h300, 32'h3);
		chk(port_disconnect, 1'b0);
		wr(12'h300, 32'h3);
		@(negedge ref_clk);
		chk(irq, 1'b0);
		// Dry rest of one second comes before the next sample request
		n = 0;
		while (adc_req !== 1'b1 && n < 4200)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk(n >= 4000 && n <= 4100, 1);
		$display("test liquid done");
		close_out();
	end
endmodule : tb_top

bind slq_regs slq_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) slq_regs_chk_inst (.ref_clk(ref_clk),
	.resetn(resetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .device_idle(device_idle),
	.gpio_dir(gpio_dir), .gpio_level(gpio_level), .adc_valid(adc_valid), .adc_data(adc_data),
	.adc_req(adc_req), .sleep_mode(sleep_mode), .liquid_present(liquid_present), .irq(irq),
	.port_disconnect(port_disconnect), .port_disable(port_disable), .cc_pulldown(cc_pulldown));
